// File: logic/diec_cfg.svh
// Offsets, reset values and timing figures of the edge counter channel
`ifndef DIEC_CFG_SVH
`define DIEC_CFG_SVH

`define DIEC_ADDR_W 6
`define DIEC_FILT_W 20
`define DIEC_CLK_MHZ 25

// Input delay choices in microseconds
`define DIEC_DLY0_US 50
`define DIEC_DLY1_US 100
`define DIEC_DLY2_US 400
`define DIEC_DLY3_US 800
`define DIEC_DLY4_US 1600
`define DIEC_DLY5_US 3200
`define DIEC_DLY6_US 12800
`define DIEC_DLY7_US 20000

// Register byte offsets
`define DIEC_OFS_CTRL 6'h00
`define DIEC_OFS_CFG 6'h04
`define DIEC_OFS_LDVAL 6'h08
`define DIEC_OFS_LDCODE 6'h0C
`define DIEC_OFS_STATUS 6'h10
`define DIEC_OFS_COUNT 6'h14
`define DIEC_OFS_HIGH 6'h18
`define DIEC_OFS_LOW 6'h1C
`define DIEC_OFS_START 6'h20
`define DIEC_OFS_CMP 6'h24
`define DIEC_OFS_CMP0 6'h28
`define DIEC_OFS_CMP1 6'h2C

// Reset values: channel enabled, 3.2 ms delay, rising edge, continue
`define DIEC_CTRL_RST 32'h00000001
`define DIEC_CFG_RST 32'h00000005
`define DIEC_HIGH_RST 32'h7FFFFFFF
`define DIEC_LOW_RST 32'h00000000
`define DIEC_START_RST 32'h00000000
`define DIEC_CMP_RST 32'h0000000A
`define DIEC_CMP0_RST 32'h00000000
`define DIEC_CMP1_RST 32'h0000000A
`define DIEC_ZERO32 32'h00000000
`define DIEC_ONE32 32'sh00000001
`define DIEC_DLY_SHORTEST 3'h0

`endif

// File: logic/diec_pkg.sv
// Types shared by the edge counter channel
package diec_pkg;

  typedef enum logic [2:0] {
    DIEC_OUT_LOW = 3'h0,
    DIEC_OUT_HIGH = 3'h1,
    DIEC_OUT_WIN = 3'h2,
    DIEC_OUT_OUTSIDE = 3'h3,
    DIEC_OUT_UPPER = 3'h4,
    DIEC_OUT_LOWER = 3'h5
  } diec_outmode_t;

  typedef enum logic [1:0] {
    DIEC_EDGE_RISE = 2'h0,
    DIEC_EDGE_FALL = 2'h1,
    DIEC_EDGE_BOTH = 2'h2
  } diec_edge_t;

  typedef enum logic [1:0] {
    DIEC_FN_NONE = 2'h0,
    DIEC_FN_GATE = 2'h1,
    DIEC_FN_DIR = 2'h2
  } diec_compfn_t;

  typedef enum logic [3:0] {
    DIEC_LD_COUNT = 4'h1,
    DIEC_LD_START = 4'h3,
    DIEC_LD_CMP = 4'h4,
    DIEC_LD_CMP0 = 4'h5,
    DIEC_LD_CMP1 = 4'h6,
    DIEC_LD_HIGH = 4'h7,
    DIEC_LD_LOW = 4'h8
  } diec_ldcode_t;

  typedef struct packed {
    logic [26:0] rsvd;
    logic irqEn;
    logic faultClearReq;
    logic eventClearReq;
    logic swGate;
    logic enable;
  } diec_ctrl_t;

  typedef struct packed {
    logic [18:0] rsvd;
    logic isoMode;
    logic [1:0] companionFn;
    logic [2:0] outMode;
    logic dirDown;
    logic [1:0] edgeSel;
    logic stopOnViolation;
    logic [2:0] delaySel;
  } diec_cfg_t;

  typedef struct packed {
    logic [21:0] rsvd;
    logic isoActive;
    logic gateOpen;
    logic underflowEventLatch;
    logic overflowEventLatch;
    logic compareEventLatchA;
    logic eventClearAck;
    logic loadFaultFlag;
    logic loadDoneToggle;
    logic companionLevel;
    logic compareOutputState;
  } diec_status_t;

endpackage

// File: logic/diec_counter.sv
// Debounced edge counter channel with limits, compare output and registers
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "diec_cfg.svh"
module diec_counter #(
  parameter int unsigned DELAY_CYC_0 = `DIEC_DLY0_US * `DIEC_CLK_MHZ,
  parameter int unsigned DELAY_CYC_1 = `DIEC_DLY1_US * `DIEC_CLK_MHZ,
  parameter int unsigned DELAY_CYC_2 = `DIEC_DLY2_US * `DIEC_CLK_MHZ,
  parameter int unsigned DELAY_CYC_3 = `DIEC_DLY3_US * `DIEC_CLK_MHZ,
  parameter int unsigned DELAY_CYC_4 = `DIEC_DLY4_US * `DIEC_CLK_MHZ,
  parameter int unsigned DELAY_CYC_5 = `DIEC_DLY5_US * `DIEC_CLK_MHZ,
  parameter int unsigned DELAY_CYC_6 = `DIEC_DLY6_US * `DIEC_CLK_MHZ,
  parameter int unsigned DELAY_CYC_7 = `DIEC_DLY7_US * `DIEC_CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [`DIEC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic countPulseInput,
  input wire logic companionInput,
  input wire logic isoReadStrobe,
  output logic compareOutputState,
  output logic compareIrq
);
  import diec_pkg::*;

  function automatic logic inRange(input logic signed [31:0] v,
                                   input logic signed [31:0] lo,
                                   input logic signed [31:0] hi);
    inRange = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] wr,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    mergeBytes = res;
  endfunction

  function automatic logic [`DIEC_FILT_W-1:0] delayCycles(
      input logic [2:0] sel);
    case (sel)
      3'h0: delayCycles = `DIEC_FILT_W'(DELAY_CYC_0);
      3'h1: delayCycles = `DIEC_FILT_W'(DELAY_CYC_1);
      3'h2: delayCycles = `DIEC_FILT_W'(DELAY_CYC_2);
      3'h3: delayCycles = `DIEC_FILT_W'(DELAY_CYC_3);
      3'h4: delayCycles = `DIEC_FILT_W'(DELAY_CYC_4);
      3'h5: delayCycles = `DIEC_FILT_W'(DELAY_CYC_5);
      3'h6: delayCycles = `DIEC_FILT_W'(DELAY_CYC_6);
      default: delayCycles = `DIEC_FILT_W'(DELAY_CYC_7);
    endcase
  endfunction

  // Input synchronisers and debounce filters, bit 0 count, bit 1 companion
  logic [1:0] syncA_r, syncB_r, syncC_r;
  logic [1:0] filtLvl_r, filtLvl_nxt, filtPrev_r;
  logic [`DIEC_FILT_W-1:0] filtCnt_r [2];
  logic [`DIEC_FILT_W-1:0] filtCnt_nxt [2];
  logic [`DIEC_FILT_W-1:0] dlyNow;

  // Bus slave and software-written registers
  diec_ctrl_t ctrl_r, ctrl_nxt;
  diec_cfg_t cfg_r, cfg_nxt;
  logic signed [31:0] ldVal_r, ldVal_nxt;
  logic [3:0] ldCode_r, ldCode_nxt;
  logic busAck_r, busAck_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic busWr, ldStrobe;

  // Counter state
  logic signed [31:0] count_r, count_nxt;
  logic signed [31:0] high_r, high_nxt, low_r, low_nxt;
  logic signed [31:0] start_r, start_nxt, cmp_r, cmp_nxt;
  logic signed [31:0] cmp0_r, cmp0_nxt, cmp1_r, cmp1_nxt;
  logic stop_r, stop_nxt, swGatePrev_r;
  logic cmpOut_r, cmpOut_nxt, evCmp_r, evCmp_nxt;
  logic evOvf_r, evOvf_nxt, evUnf_r, evUnf_nxt;
  logic evAck_r, evAck_nxt, irq_r, irq_nxt;
  logic ldToggle_r, ldToggle_nxt, ldFault_r, ldFault_nxt;
  logic startLoad, ovfHit, unfHit, cmpHit, ldValid;
  logic hwGate, gateReq, gateOpen, countDown, edgeHit;
  logic riseSeen, fallSeen, isoActive, fbUpdate;
  diec_edge_t edgeEff;
  diec_status_t statusNow;
  diec_status_t fbStatus_r, fbStatus_nxt;
  logic signed [31:0] fbCount_r, fbCount_nxt;

  // ---------------- Input filter ----------------
  assign dlyNow = delayCycles(cfg_r.delaySel);

  always_comb begin
    filtLvl_nxt = filtLvl_r;
    for (int i = 0; i < 2; i++) begin
      filtCnt_nxt[i] = '0;
      // Only a level on which the last two stages agree is taken
      if ((syncB_r[i] == syncC_r[i]) && (syncC_r[i] != filtLvl_r[i])) begin
        if (filtCnt_r[i] >= dlyNow) begin
          filtLvl_nxt[i] = syncC_r[i];
        end else begin
          filtCnt_nxt[i] = filtCnt_r[i] + `DIEC_FILT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_r <= 2'h0;
      syncB_r <= 2'h0;
      syncC_r <= 2'h0;
      filtLvl_r <= 2'h0;
      filtPrev_r <= 2'h0;
      filtCnt_r[0] <= '0;
      filtCnt_r[1] <= '0;
    end else begin
      syncA_r <= {companionInput, countPulseInput};
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
      filtLvl_r <= filtLvl_nxt;
      filtPrev_r <= filtLvl_r;
      filtCnt_r[0] <= filtCnt_nxt[0];
      filtCnt_r[1] <= filtCnt_nxt[1];
    end
  end

  // ---------------- Avalon-MM slave ----------------
  // One wait cycle per access; read data is captured in that cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~busAck_r;
  assign avs_readdata = rdata_r;
  assign busWr = avs_write & busAck_r;
  assign ldStrobe = busWr && ({avs_address[5:2], 2'h0} == `DIEC_OFS_LDCODE);

  always_comb begin
    busAck_nxt = (avs_read | avs_write) & ~busAck_r;
    rdata_nxt = rdata_r;
    ctrl_nxt = ctrl_r;
    cfg_nxt = cfg_r;
    ldVal_nxt = ldVal_r;
    ldCode_nxt = ldCode_r;
    if (avs_read && !busAck_r) begin
      case ({avs_address[5:2], 2'h0})
        `DIEC_OFS_CTRL: rdata_nxt = ctrl_r;
        `DIEC_OFS_CFG: rdata_nxt = cfg_r;
        `DIEC_OFS_LDVAL: rdata_nxt = ldVal_r;
        `DIEC_OFS_LDCODE: rdata_nxt = {28'h0000000, ldCode_r};
        `DIEC_OFS_STATUS: rdata_nxt = fbStatus_r;
        `DIEC_OFS_COUNT: rdata_nxt = fbCount_r;
        `DIEC_OFS_HIGH: rdata_nxt = high_r;
        `DIEC_OFS_LOW: rdata_nxt = low_r;
        `DIEC_OFS_START: rdata_nxt = start_r;
        `DIEC_OFS_CMP: rdata_nxt = cmp_r;
        `DIEC_OFS_CMP0: rdata_nxt = cmp0_r;
        `DIEC_OFS_CMP1: rdata_nxt = cmp1_r;
        default: rdata_nxt = `DIEC_ZERO32;
      endcase
    end
    if (busWr) begin
      case ({avs_address[5:2], 2'h0})
        `DIEC_OFS_CTRL: ctrl_nxt = mergeBytes(ctrl_r, avs_writedata,
                                              avs_byteenable);
        `DIEC_OFS_CFG: cfg_nxt = mergeBytes(cfg_r, avs_writedata,
                                            avs_byteenable);
        `DIEC_OFS_LDVAL: ldVal_nxt = mergeBytes(ldVal_r, avs_writedata,
                                                avs_byteenable);
        `DIEC_OFS_LDCODE: ldCode_nxt = avs_writedata[3:0];
        default: ldCode_nxt = ldCode_r;
      endcase
    end
    // Reserved bits stay zero so they read back as zero
    ctrl_nxt.rsvd = '0;
    cfg_nxt.rsvd = '0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busAck_r <= 1'b0;
      rdata_r <= `DIEC_ZERO32;
      ctrl_r <= `DIEC_CTRL_RST;
      cfg_r <= `DIEC_CFG_RST;
      ldVal_r <= `DIEC_ZERO32;
      ldCode_r <= 4'h0;
    end else begin
      busAck_r <= busAck_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      cfg_r <= cfg_nxt;
      ldVal_r <= ldVal_nxt;
      ldCode_r <= ldCode_nxt;
    end
  end

  // ---------------- Counter core ----------------
  assign hwGate = (cfg_r.companionFn == DIEC_FN_GATE) ?
                  filtLvl_r[1] : 1'b1;
  assign gateReq = ctrl_r.swGate & hwGate;
  assign gateOpen = ctrl_r.enable & gateReq & ~stop_r;
  assign countDown = (cfg_r.companionFn == DIEC_FN_DIR) ?
                     filtLvl_r[1] : cfg_r.dirDown;
  assign riseSeen = filtLvl_r[0] & ~filtPrev_r[0];
  assign fallSeen = ~filtLvl_r[0] & filtPrev_r[0];

  always_comb begin
    edgeEff = diec_edge_t'(cfg_r.edgeSel);
    // Counting down under companion control uses the opposite edge
    if ((cfg_r.companionFn == DIEC_FN_DIR) && filtLvl_r[1]) begin
      if (edgeEff == DIEC_EDGE_RISE) begin
        edgeEff = DIEC_EDGE_FALL;
      end else if (edgeEff == DIEC_EDGE_FALL) begin
        edgeEff = DIEC_EDGE_RISE;
      end
    end
    case (edgeEff)
      DIEC_EDGE_RISE: edgeHit = riseSeen;
      DIEC_EDGE_FALL: edgeHit = fallSeen;
      DIEC_EDGE_BOTH: edgeHit = riseSeen | fallSeen;
      default: edgeHit = 1'b0;
    endcase
  end

  always_comb begin
    count_nxt = count_r;
    high_nxt = high_r;
    low_nxt = low_r;
    start_nxt = start_r;
    cmp_nxt = cmp_r;
    cmp0_nxt = cmp0_r;
    cmp1_nxt = cmp1_r;
    stop_nxt = stop_r;
    startLoad = 1'b0;
    ovfHit = 1'b0;
    unfHit = 1'b0;
    ldValid = 1'b0;
    ldToggle_nxt = ldToggle_r;
    ldFault_nxt = ldFault_r;
    evCmp_nxt = evCmp_r;
    evOvf_nxt = evOvf_r;
    evUnf_nxt = evUnf_r;
    evAck_nxt = evAck_r;
    // Closing either gate re-arms counting after an automatic stop
    if (!gateReq) begin
      stop_nxt = 1'b0;
    end
    if (ctrl_r.swGate && !swGatePrev_r) begin
      count_nxt = start_r;
      startLoad = 1'b1;
    end else if (gateOpen && edgeHit) begin
      if (!countDown) begin
        if (count_r == high_r) begin
          count_nxt = low_r;
          ovfHit = 1'b1;
          stop_nxt = cfg_r.stopOnViolation;
        end else begin
          count_nxt = count_r + `DIEC_ONE32;
        end
      end else begin
        if (count_r == low_r) begin
          count_nxt = high_r;
          unfHit = 1'b1;
          stop_nxt = cfg_r.stopOnViolation;
        end else begin
          count_nxt = count_r - `DIEC_ONE32;
        end
      end
    end
    // Each code checks the ordering of limits and comparison values
    if (ldStrobe) begin
      case (avs_writedata[3:0])
        DIEC_LD_COUNT: begin
          ldValid = inRange(ldVal_r, low_r, high_r);
          if (ldValid) count_nxt = ldVal_r;
        end
        DIEC_LD_START: begin
          ldValid = inRange(ldVal_r, low_r, high_r);
          if (ldValid) start_nxt = ldVal_r;
        end
        DIEC_LD_CMP: begin
          ldValid = inRange(ldVal_r, low_r, high_r);
          if (ldValid) cmp_nxt = ldVal_r;
        end
        DIEC_LD_CMP0: begin
          ldValid = (ldVal_r >= low_r) && (ldVal_r < cmp1_r);
          if (ldValid) cmp0_nxt = ldVal_r;
        end
        DIEC_LD_CMP1: begin
          ldValid = (ldVal_r > cmp0_r) && (ldVal_r <= high_r);
          if (ldValid) cmp1_nxt = ldVal_r;
        end
        DIEC_LD_HIGH: begin
          ldValid = ldVal_r > low_r;
          if (ldValid) high_nxt = ldVal_r;
        end
        DIEC_LD_LOW: begin
          ldValid = ldVal_r < high_r;
          if (ldValid) low_nxt = ldVal_r;
        end
        default: ldValid = 1'b0;
      endcase
      ldToggle_nxt = ldToggle_r ^ ldValid;
    end
    if (ctrl_r.faultClearReq) begin
      ldFault_nxt = 1'b0;
    end
    if (ldStrobe && !ldValid) begin
      ldFault_nxt = 1'b1;
    end
    if (!ctrl_r.enable) begin
      cmpOut_nxt = 1'b0;
    end else begin
      case (diec_outmode_t'(cfg_r.outMode))
        DIEC_OUT_LOW: cmpOut_nxt = 1'b0;
        DIEC_OUT_HIGH: cmpOut_nxt = 1'b1;
        DIEC_OUT_WIN: cmpOut_nxt = inRange(count_nxt, cmp0_nxt,
                                           cmp1_nxt);
        DIEC_OUT_OUTSIDE: cmpOut_nxt = !inRange(count_nxt, cmp0_nxt,
                                                cmp1_nxt);
        DIEC_OUT_UPPER: cmpOut_nxt = inRange(count_nxt, cmp_nxt,
                                             high_nxt);
        DIEC_OUT_LOWER: cmpOut_nxt = inRange(count_nxt, low_nxt,
                                             cmp_nxt);
        default: cmpOut_nxt = 1'b0;
      endcase
    end
    cmpHit = (cmpOut_nxt != cmpOut_r) && !startLoad;
    if (ctrl_r.eventClearReq && !evAck_r) begin
      evCmp_nxt = 1'b0;
      evOvf_nxt = 1'b0;
      evUnf_nxt = 1'b0;
      evAck_nxt = 1'b1;
    end else if (!ctrl_r.eventClearReq && evAck_r) begin
      evAck_nxt = 1'b0;
    end
    // A new event in the clearing cycle stays latched
    if (cmpHit) evCmp_nxt = 1'b1;
    if (ovfHit) evOvf_nxt = 1'b1;
    if (unfHit) evUnf_nxt = 1'b1;
    irq_nxt = cmpHit & ctrl_r.irqEn;
  end

  // ---------------- Feedback snapshot ----------------
  // Shortest delay is the only setting fast enough for isochronous reads
  assign isoActive = cfg_r.isoMode &&
                     (cfg_r.delaySel == `DIEC_DLY_SHORTEST);
  assign fbUpdate = !isoActive || isoReadStrobe;

  always_comb begin
    statusNow = '0;
    statusNow.isoActive = isoActive;
    statusNow.gateOpen = gateOpen;
    statusNow.underflowEventLatch = evUnf_r;
    statusNow.overflowEventLatch = evOvf_r;
    statusNow.compareEventLatchA = evCmp_r;
    statusNow.eventClearAck = evAck_r;
    statusNow.loadFaultFlag = ldFault_r;
    statusNow.loadDoneToggle = ldToggle_r;
    statusNow.companionLevel = filtLvl_r[1];
    statusNow.compareOutputState = cmpOut_r;
    fbStatus_nxt = fbUpdate ? statusNow : fbStatus_r;
    fbCount_nxt = fbUpdate ? count_r : fbCount_r;
  end

  assign compareOutputState = cmpOut_r;
  assign compareIrq = irq_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= `DIEC_START_RST;
      high_r <= `DIEC_HIGH_RST;
      low_r <= `DIEC_LOW_RST;
      start_r <= `DIEC_START_RST;
      cmp_r <= `DIEC_CMP_RST;
      cmp0_r <= `DIEC_CMP0_RST;
      cmp1_r <= `DIEC_CMP1_RST;
      stop_r <= 1'b0;
      swGatePrev_r <= 1'b0;
      cmpOut_r <= 1'b0;
      evCmp_r <= 1'b0;
      evOvf_r <= 1'b0;
      evUnf_r <= 1'b0;
      evAck_r <= 1'b0;
      irq_r <= 1'b0;
      ldToggle_r <= 1'b0;
      ldFault_r <= 1'b0;
      fbStatus_r <= '0;
      fbCount_r <= `DIEC_START_RST;
    end else begin
      count_r <= count_nxt;
      high_r <= high_nxt;
      low_r <= low_nxt;
      start_r <= start_nxt;
      cmp_r <= cmp_nxt;
      cmp0_r <= cmp0_nxt;
      cmp1_r <= cmp1_nxt;
      stop_r <= stop_nxt;
      swGatePrev_r <= ctrl_r.swGate;
      cmpOut_r <= cmpOut_nxt;
      evCmp_r <= evCmp_nxt;
      evOvf_r <= evOvf_nxt;
      evUnf_r <= evUnf_nxt;
      evAck_r <= evAck_nxt;
      irq_r <= irq_nxt;
      ldToggle_r <= ldToggle_nxt;
      ldFault_r <= ldFault_nxt;
      fbStatus_r <= fbStatus_nxt;
      fbCount_r <= fbCount_nxt;
    end
  end

endmodule
`default_nettype wire

// File: verification/diec_counter_props.sv
// Port-level assertions for the edge counter channel
`timescale 1ns/1ps
`default_nettype none
`include "diec_cfg.svh"
module diec_counter_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [`DIEC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic countPulseInput,
  input wire logic companionInput,
  input wire logic isoReadStrobe,
  input wire logic compareOutputState,
  input wire logic compareIrq
);
  import diec_pkg::*;
  // Shadows assume full-word writes, which is all the bench issues
  diec_ctrl_t ctrlSh_r, ctrlSh_nxt;
  diec_cfg_t cfgSh_r, cfgSh_nxt;
  logic [2:0] age_r, age_nxt;
  logic wrDone, quiet;
  always_comb begin
    wrDone = avs_write && !avs_waitrequest;
    ctrlSh_nxt = ctrlSh_r;
    cfgSh_nxt = cfgSh_r;
    age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
    if (wrDone && avs_address == `DIEC_OFS_CTRL) begin
      ctrlSh_nxt = avs_writedata;
      age_nxt = 3'h0;
    end
    if (wrDone && avs_address == `DIEC_OFS_CFG) begin
      cfgSh_nxt = avs_writedata;
      age_nxt = 3'h0;
    end
    // Iso mode may freeze feedback, so level checks skip it
    quiet = !cfgSh_r.isoMode && age_r > 3'h2;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlSh_r <= `DIEC_CTRL_RST;
      cfgSh_r <= `DIEC_CFG_RST;
      age_r <= 3'h0;
    end else begin
      ctrlSh_r <= ctrlSh_nxt;
      cfgSh_r <= cfgSh_nxt;
      age_r <= age_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_wait_once: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request waited over one cycle");
  a_ctrl_back: assert property (
    avs_read && !avs_waitrequest && avs_address == `DIEC_OFS_CTRL
    |-> avs_readdata[0] == ctrlSh_r.enable)
    else $error("enable bit readback wrong");
  a_cfg_back: assert property (
    avs_read && !avs_waitrequest && avs_address == `DIEC_OFS_CFG
    |-> avs_readdata[12:0] == cfgSh_r[12:0])
    else $error("config readback wrong");
  a_forced_high: assert property (
    quiet && ctrlSh_r.enable && cfgSh_r.outMode == DIEC_OUT_HIGH
    |-> compareOutputState) else $error("forced high output not high");
  a_forced_low: assert property (
    quiet && cfgSh_r.outMode == DIEC_OUT_LOW |-> !compareOutputState)
    else $error("forced low output not low");
  a_disabled_low: assert property (
    quiet && !ctrlSh_r.enable |-> !compareOutputState)
    else $error("disabled channel output high");
  a_irq_gated: assert property (
    compareIrq |-> ctrlSh_r.irqEn || $past(ctrlSh_r.irqEn))
    else $error("interrupt while masked");
  a_irq_change: assert property (
    !cfgSh_r.isoMode && compareIrq
    |-> compareOutputState != $past(compareOutputState))
    else $error("interrupt without compare change");
  c_irq: cover property (compareIrq);
  c_high: cover property (quiet && compareOutputState);
  c_cfg_read: cover property (avs_read && !avs_waitrequest &&
    avs_address == `DIEC_OFS_CFG);
endmodule
bind diec_counter diec_counter_props u_props (.clk, .rst_b, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .countPulseInput, .companionInput, .isoReadStrobe,
  .compareOutputState, .compareIrq);
`default_nettype wire

// File: verification/diec_pin_src.sv
// Process signal source model for the count and companion pins
`timescale 1ns/1ps
`default_nettype none
module diec_pin_src (
  input wire logic clk,
  output logic countPulseInput,
  output logic companionInput
);
  initial begin
    countPulseInput = 1'b0;
    companionInput = 1'b0;
  end
  // Width w sets how slowly the source toggles; keep it above the delay
  task automatic pulse(input int n, input int w);
    repeat (n) begin
      @(posedge clk) countPulseInput <= 1'b1;
      repeat (w) @(posedge clk);
      countPulseInput <= 1'b0;
      repeat (w) @(posedge clk);
    end
  endtask
  task automatic companion(input logic lvl);
    @(posedge clk) companionInput <= lvl;
    repeat (24) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: verification/diec_counter_tb.sv
// Self-checking bench for the edge counter channel
`timescale 1ns/1ps
`default_nettype none
module diec_counter_tb;
  import diec_pkg::*;
  logic clk, rst_b, busRd, busWr, busWait, strobe, cnt, comp, cos, irq, t;
  logic [5:0] busAddr;
  logic [31:0] busWdata, busRdata, v;
  int num_errors, checks, irqSeen;
  logic [5:0] ofs [9] = '{6'h00, 6'h04, 6'h18, 6'h1C, 6'h20, 6'h24, 6'h28,
    6'h2C, 6'h30};
  logic [31:0] rstv [9] = '{32'h1, 32'h5, 32'h7FFFFFFF, 32'h0, 32'h0, 32'hA,
    32'h0, 32'hA, 32'h0};
  int cv [4] = '{0, 5, 10, 11};
  diec_counter #(.DELAY_CYC_0(4), .DELAY_CYC_5(14)) dut (.clk(clk),
    .rst_b(rst_b), .avs_address(busAddr), .avs_read(busRd),
    .avs_write(busWr), .avs_writedata(busWdata), .avs_byteenable(4'hF),
    .avs_readdata(busRdata), .avs_waitrequest(busWait),
    .countPulseInput(cnt), .companionInput(comp), .isoReadStrobe(strobe),
    .compareOutputState(cos), .compareIrq(irq));
  diec_pin_src src (.clk(clk), .countPulseInput(cnt), .companionInput(comp));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (irq === 1'b1) irqSeen++;
  task automatic report_and_stop;
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until waitrequest is sampled low, then released
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    // Feedback lags state by one edge; idle edges let it settle first
    repeat (3) @(posedge clk);
    busAddr <= a;
    busWdata <= d;
    busWr <= w;
    busRd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (busWait !== 1'b0 && n < 50);
    if (n >= 50) num_errors++;
    v = busRdata;
    busWr <= 1'b0;
    busRd <= 1'b0;
  endtask
  task automatic load(input logic [3:0] code, input logic [31:0] val);
    bus(1'b1, 6'h08, val);
    bus(1'b1, 6'h0C, {28'h0, code});
  endtask
  function automatic logic [31:0] cfgv(input logic stop, input logic [1:0] e,
    input logic dn, input logic [2:0] om, input logic [1:0] fn, input logic i);
    return {19'h0, i, fn, om, dn, e, stop, 3'h0};
  endfunction
  // Compare values at their defaults: cmp0 0, cmp1 10, single 10
  function automatic logic expCmp(input logic [2:0] m, input int c);
    case (m)
      3'h2: return c >= 0 && c <= 10;
      3'h3: return c < 0 || c > 10;
      3'h4: return c >= 10;
      default: return c <= 10;
    endcase
  endfunction
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop;
  end
  initial begin
    {busAddr, busRd, busWr, busWdata, strobe, rst_b} = '0;
    num_errors = 0;
    checks = 0;
    irqSeen = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, ofs[i], 32'h0);
      check(v, rstv[i]);
    end
    bus(1'b1, 6'h00, 32'h3);
    for (int m = 2; m < 6; m++) begin
      bus(1'b1, 6'h04, cfgv(0, 2'h0, 0, m[2:0], 2'h0, 0));
      foreach (cv[j]) begin
        load(4'h1, cv[j]);
        bus(1'b0, 6'h10, 32'h0);
        check(cos, expCmp(m[2:0], cv[j]));
      end
    end
    for (int e = 0; e < 3; e++) begin
      bus(1'b1, 6'h04, cfgv(0, e[1:0], 0, 3'h0, 2'h0, 0));
      load(4'h1, 32'h0);
      src.pulse(2, 12);
      bus(1'b0, 6'h14, 32'h0);
      check(v, e == 2 ? 32'h4 : 32'h2);
    end
    bus(1'b1, 6'h04, cfgv(0, 2'h0, 0, 3'h0, 2'h0, 0));
    load(4'h7, 32'h5);
    load(4'h1, 32'h4);
    src.pulse(2, 12);
    bus(1'b0, 6'h14, 32'h0);
    check(v, 32'h0);
    bus(1'b1, 6'h00, 32'h7);
    bus(1'b0, 6'h10, 32'h0);
    check(v[6:4], 3'h1);
    bus(1'b1, 6'h00, 32'h3);
    bus(1'b0, 6'h10, 32'h0);
    check(v[4], 1'b0);
    bus(1'b1, 6'h04, cfgv(0, 2'h0, 1, 3'h0, 2'h0, 0));
    src.pulse(2, 12);
    bus(1'b0, 6'h14, 32'h0);
    check(v, 32'h4);
    bus(1'b1, 6'h04, cfgv(1, 2'h0, 0, 3'h0, 2'h0, 0));
    load(4'h1, 32'h4);
    src.pulse(3, 12);
    bus(1'b0, 6'h14, 32'h0);
    check(v, 32'h0);
    bus(1'b1, 6'h00, 32'h1);
    bus(1'b1, 6'h00, 32'h3);
    src.pulse(1, 2);
    src.pulse(1, 12);
    bus(1'b0, 6'h14, 32'h0);
    check(v, 32'h1);
    bus(1'b0, 6'h10, 32'h0);
    t = v[2];
    load(4'h2, 32'h7);
    bus(1'b0, 6'h10, 32'h0);
    check(v[3:2], {1'b1, t});
    bus(1'b1, 6'h00, 32'hB);
    bus(1'b1, 6'h00, 32'h3);
    load(4'h1, 32'h2);
    bus(1'b0, 6'h10, 32'h0);
    check(v[3:2], {1'b0, !t});
    load(4'h5, 32'hA);
    bus(1'b0, 6'h10, 32'h0);
    check(v[3], 1'b1);
    bus(1'b1, 6'h04, cfgv(0, 2'h0, 0, 3'h0, 2'h1, 0));
    load(4'h1, 32'h0);
    src.pulse(2, 12);
    src.companion(1'b1);
    bus(1'b0, 6'h14, 32'h0);
    check(v, 32'h0);
    bus(1'b0, 6'h10, 32'h0);
    check(v[1], 1'b1);
    src.pulse(2, 12);
    bus(1'b0, 6'h14, 32'h0);
    check(v, 32'h2);
    bus(1'b1, 6'h04, cfgv(0, 2'h0, 0, 3'h0, 2'h2, 0));
    load(4'h1, 32'h3);
    src.pulse(1, 12);
    bus(1'b0, 6'h14, 32'h0);
    check(v, 32'h2);
    src.companion(1'b0);
    src.pulse(1, 12);
    bus(1'b0, 6'h14, 32'h0);
    check(v, 32'h3);
    check(irqSeen, 32'h0);
    bus(1'b1, 6'h00, 32'h13);
    bus(1'b1, 6'h04, cfgv(0, 2'h0, 0, 3'h1, 2'h0, 0));
    bus(1'b0, 6'h10, 32'h0);
    check(cos, 1'b1);
    check(irqSeen, 32'h1);
    bus(1'b1, 6'h00, 32'h0);
    bus(1'b0, 6'h10, 32'h0);
    check(cos, 1'b0);
    bus(1'b1, 6'h00, 32'h3);
    bus(1'b1, 6'h04, cfgv(0, 2'h0, 0, 3'h1, 2'h0, 1));
    src.pulse(1, 12);
    bus(1'b0, 6'h14, 32'h0);
    check(v, 32'h0);
    @(posedge clk) strobe <= 1'b1;
    @(posedge clk) strobe <= 1'b0;
    bus(1'b0, 6'h14, 32'h0);
    check(v, 32'h1);
    report_and_stop;
  end
endmodule
`default_nettype wire
